// ===== pmcm_pkg.sv
// shared constants and carrier types for the power mode clock manager
package pmcm_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RST_MIN_NS = 64;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARMUP_CLKS = 65536;
  localparam int WDT_RESET_CLKS = 512;
  localparam int DIV_W = 11;
  localparam logic [1:0] CD_RSVD = 2'h0;
  localparam logic [1:0] CD_DIV4 = 2'h1;
  localparam logic [1:0] CD_DIV64 = 2'h2;
  localparam logic [1:0] CD_DIV1024 = 2'h3;
  localparam logic [1:0] CD_RESET = CD_DIV4;
  localparam logic [DIV_W-1:0] DIV4_LAST = 11'h003;
  localparam logic [DIV_W-1:0] DIV64_LAST = 11'h03f;
  localparam logic [DIV_W-1:0] DIV1024_LAST = 11'h3ff;
  localparam int C4_PHASE = 3;

  typedef enum logic [2:0] {
    PMCM_RUN,
    PMCM_IDLE,
    PMCM_PDOWN,
    PMCM_WARM,
    PMCM_RESET
  } pmcm_mode_e;

  // software control writes, one-cycle strobes with data
  typedef struct packed {
    logic idle_wr;
    logic pdown_wr;
    logic div_wr;
    logic [1:0] div_val;
    logic src_wr;
    logic src_val;
    logic xoff_wr;
    logic xoff_val;
    logic swb_wr;
    logic swb_val;
    logic rcw_wr;
    logic rcw_val;
  } pmcm_ctrl_s;

  // pin levels driven while in low-power modes
  typedef struct packed {
    logic ale;
    logic prog_store_strobe;
    logic rd_n;
    logic wr_n;
    logic port0_float;
    logic port_hold;
  } pmcm_pins_s;

  function automatic logic [DIV_W-1:0] pmcm_div_last(input logic [1:0] cd);
    case (cd)
      CD_DIV64: pmcm_div_last = DIV64_LAST;
      CD_DIV1024: pmcm_div_last = DIV1024_LAST;
      default: pmcm_div_last = DIV4_LAST;
    endcase
  endfunction : pmcm_div_last
endpackage : pmcm_pkg

// ===== pmcm_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module pmcm_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pmcm_sync_s;
  pmcm_sync_s st;
  pmcm_sync_s next_st;

  always_comb begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;
endmodule : pmcm_sync

// ===== pmcm_warmup.sv
// oscillator warm-up counter, pulses done after the load count elapses
`timescale 1ns/100ps
module pmcm_warmup #(
  parameter int unsigned COUNT = 65536
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [31:0] cnt;
  } pmcm_wu_s;
  pmcm_wu_s st;
  pmcm_wu_s next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start_i && !st.busy) begin
      next_st.busy = 1'b1;
      next_st.cnt = 32'(COUNT - 1);
    end else if (st.busy) begin
      if (st.cnt == 32'h0) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o = st.busy;
  assign done_o = st.done;
endmodule : pmcm_warmup

// ===== pmcm_top.sv
// power mode and machine-cycle clock manager
//
// Behaviour
// - idle bit write enters idle after the writing instruction completes
// - idle gates only cpu clock; peripherals keep their clock
// - idle: strobes high, ports hold, port0 floats if running external code
// - enabled interrupt clears idle bit and wakes the cpu
// - reset pin must stay high two machine cycles (eight clocks at div4); any reset ends idle
// - reset out of idle restarts at zero with no start-up delay
// - watchdog runs in idle; timeout wakes; reset 512 clocks later
// - divide field: 01 gives 4, 10 gives 64, 11 gives 1024
// - economy slows peripherals too; idle peripherals run at clock/4
// - new divide takes effect after one instruction cycle
// - source select bit, rc status reports source, applied when the writing instruction completes
// - crystal ready set after warm-up; crystal select refused until then
// - switchback: interrupt or serial activity returns divide to four
// - serial switchback on start edge with rx enabled, or tx write
// - divide writes ignored during serial transfer while switchback enabled
// - pin reset, and por or watchdog reset outside power-down, force divide back to four
// - power-down bit stops clocks; strobes low, rd/wr high, ports hold, port0 floats if running external code
// - reset pin in power-down: warm-up 65536, then internal reset
// - low enabled level interrupt wakes power-down after 65536 warm-up
// - rc wake select: exit on rc, move to crystal after warm-up
// - reset pin sampled once per machine cycle at fourth state
`timescale 1ns/100ps
module pmcm_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pmcm_pkg::pmcm_ctrl_s ctrl_i,
  input wire logic instr_done_i,
  input wire logic ext_rst_pin_i,
  input wire logic por_rst_i,
  input wire logic wdt_timeout_i,
  input wire logic wdt_clear_i,
  input wire logic wdt_rst_en_i,
  input wire logic int_pending_i,
  input wire logic ext_int_ack_i,
  input wire logic global_int_enable_i,
  input wire logic lvl_int_wake_en_i,
  input wire logic lvl_int_pin_n_i,
  input wire logic ser_rx_pin_i,
  input wire logic ser_rx_en_i,
  input wire logic ser_tx_wr_i,
  input wire logic ser_busy_i,
  input wire logic ext_code_i,
  output logic cpu_clk_en_o,
  output logic periph_tick_o,
  output logic core_tick_o,
  output logic int_rst_o,
  output logic int_wake_o,
  output logic idle_bit_o,
  output logic pdown_bit_o,
  output logic [1:0] clk_div_o,
  output logic clk_src_select_o,
  output logic rc_active_status_o,
  output logic crystal_amp_off_o,
  output logic crystal_ready_o,
  output logic switchback_enable_o,
  output logic rc_wake_select_o,
  output logic osc_run_o,
  output pmcm_pkg::pmcm_pins_s pins_o
);
  import pmcm_pkg::*;

  typedef struct packed {
    pmcm_mode_e mode;
    logic idle_pend;
    logic pd_pend;
    logic pd_by_rst;
    logic [1:0] cd;
    logic [1:0] cd_pend;
    logic cd_pend_v;
    logic src;
    logic src_pend;
    logic src_pend_v;
    logic rc_act;
    logic xoff;
    logic xready;
    logic switchback_enable;
    logic rcw;
    logic rc_to_xtal;
    logic [DIV_W-1:0] ccnt;
    logic [1:0] pcnt;
    logic [3:0] rst_cnt;
    logic [9:0] wdt_cnt;
    logic wdt_arm;
    logic [1:0] hold_cnt;
    logic rx_prev;
    logic core_tick;
    logic periph_tick;
    logic int_rst;
    logic wake;
    logic warm_start;
    logic cpu_en;
    logic osc_run;
    pmcm_pins_s pins;
  } pmcm_state_s;

  pmcm_state_s st;
  pmcm_state_s next_st;
  logic rst_pin_s;
  logic rx_pin_s;
  logic lvl_n_s;
  logic wu_busy;
  logic wu_done;

  pmcm_sync #(.W(3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({ext_rst_pin_i, ser_rx_pin_i, lvl_int_pin_n_i}),
    .q_o({rst_pin_s, rx_pin_s, lvl_n_s})
  );

  // one shared warm-up counter covers oscillator restart and rc-to-crystal
  pmcm_warmup #(.COUNT(WARMUP_CLKS)) u_warm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(st.warm_start),
    .busy_o(wu_busy),
    .done_o(wu_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic c4;
  logic any_rst;
  logic sw_back;
  logic [DIV_W-1:0] last;
  always_comb begin
    next_st = st;
    next_st.core_tick = 1'b0;
    next_st.periph_tick = 1'b0;
    next_st.wake = 1'b0;
    next_st.warm_start = 1'b0;
    next_st.int_rst = 1'b0;
    last = pmcm_div_last(st.cd);
    c4 = (st.ccnt == last);
    if (st.mode != PMCM_PDOWN && st.mode != PMCM_WARM && c4) begin
      next_st.rst_cnt = rst_pin_s ? ((st.rst_cnt == 4'hf) ? st.rst_cnt : st.rst_cnt + 4'h1)
                                  : 4'h0;
    end
    // two samples span eight clocks at div4
    any_rst = por_rst_i || (c4 && rst_pin_s && st.rst_cnt >= 4'(RST_MIN_CYC / 4 - 1));
    // watchdog reset 512 clocks after timeout
    if (wdt_clear_i) begin
      next_st.wdt_arm = 1'b0;
    end else if (wdt_timeout_i && !st.wdt_arm) begin
      next_st.wdt_arm = 1'b1;
      next_st.wdt_cnt = 10'(WDT_RESET_CLKS - 1);
    end else if (st.wdt_arm) begin
      if (st.wdt_cnt == 10'h0) begin
        next_st.wdt_arm = 1'b0;
        any_rst = any_rst || wdt_rst_en_i;
      end else begin
        next_st.wdt_cnt = st.wdt_cnt - 10'h1;
      end
    end
    // machine-cycle divider; halted while clocks stopped
    if (st.mode != PMCM_PDOWN && st.mode != PMCM_WARM) begin
      next_st.ccnt = c4 ? '0 : st.ccnt + 11'h1;
      next_st.core_tick = c4 && st.mode != PMCM_IDLE;
      // idle peripherals always tick at clock/4
      next_st.pcnt = st.pcnt + 2'h1;
      next_st.periph_tick = (st.mode == PMCM_IDLE) ? (st.pcnt == 2'h3) : c4;
    end
    next_st.rx_prev = rx_pin_s;
    sw_back = st.switchback_enable && (ext_int_ack_i || ser_tx_wr_i ||
              (ser_rx_en_i && st.rx_prev && !rx_pin_s));
    // divide write gating, software keeps 64/1024 ordering
    if (ctrl_i.div_wr && !(st.switchback_enable && ser_busy_i) && ctrl_i.div_val != CD_RSVD) begin
      next_st.cd_pend = ctrl_i.div_val;
      next_st.cd_pend_v = 1'b1;
    end
    // crystal select refused while not ready
    if (ctrl_i.src_wr && (!ctrl_i.src_val || st.xready)) begin
      next_st.src_pend = ctrl_i.src_val;
      next_st.src_pend_v = 1'b1;
    end
    // amp off only honoured while on rc
    if (ctrl_i.xoff_wr) begin
      next_st.xoff = ctrl_i.xoff_val && st.rc_act;
      if (ctrl_i.xoff_val && st.rc_act) begin
        next_st.xready = 1'b0;
      end else if (!ctrl_i.xoff_val && st.xoff) begin
        next_st.warm_start = 1'b1;
      end
    end
    if (ctrl_i.swb_wr) begin
      next_st.switchback_enable = ctrl_i.swb_val;
    end
    if (ctrl_i.rcw_wr) begin
      next_st.rcw = ctrl_i.rcw_val;
    end
    if (instr_done_i && st.cd_pend_v) begin
      next_st.cd = st.cd_pend;
      next_st.cd_pend_v = 1'b0;
      next_st.ccnt = '0;
    end
    if (instr_done_i && st.src_pend_v) begin
      next_st.src = st.src_pend;
      next_st.rc_act = !st.src_pend;
      next_st.src_pend_v = 1'b0;
    end
    if (sw_back) begin
      next_st.cd = CD_DIV4;
      next_st.cd_pend_v = 1'b0;
      next_st.ccnt = '0;
    end
    if (wu_done && !st.xoff) begin
      next_st.xready = 1'b1;
      if (st.rc_to_xtal) begin
        next_st.rc_to_xtal = 1'b0;
        next_st.src = 1'b1;
        next_st.rc_act = 1'b0;
      end
    end
    case (st.mode)
      PMCM_RUN: begin
        // entry at end of the writing instruction
        if (ctrl_i.idle_wr) begin
          next_st.idle_pend = 1'b1;
        end
        if (ctrl_i.pdown_wr) begin
          next_st.pd_pend = 1'b1;
        end
        if (instr_done_i && st.pd_pend) begin
          next_st.mode = PMCM_PDOWN;
          next_st.xready = 1'b0;
        end else if (instr_done_i && st.idle_pend) begin
          next_st.mode = PMCM_IDLE;
        end
      end
      PMCM_IDLE: begin
        if (int_pending_i || wdt_timeout_i) begin
          next_st.mode = PMCM_RUN;
          next_st.idle_pend = 1'b0;
          next_st.wake = 1'b1;
        end
      end
      PMCM_PDOWN: begin
        // wake sources; watchdog timeout neither wakes nor resets here
        if (rst_pin_s || (!lvl_n_s && lvl_int_wake_en_i && global_int_enable_i)) begin
          next_st.mode = PMCM_WARM;
          next_st.pd_by_rst = rst_pin_s;
          next_st.warm_start = 1'b1;
          if (st.rcw) begin
            next_st.rc_to_xtal = 1'b1;
            next_st.src = 1'b0;
            next_st.rc_act = 1'b1;
          end
        end
      end
      PMCM_WARM: begin
        // rc wake runs at once, crystal wake waits for warm-up
        if (st.rc_to_xtal || wu_done) begin
          next_st.pd_pend = 1'b0;
          next_st.mode = st.pd_by_rst ? PMCM_RESET : PMCM_RUN;
          next_st.wake = !st.pd_by_rst;
          next_st.hold_cnt = 2'h3;
        end
      end
      PMCM_RESET: begin
        next_st.int_rst = 1'b1;
        // divide forced back to four on entry and held there through reset
        next_st.cd = CD_RESET;
        next_st.cd_pend_v = 1'b0;
        if (st.cd != CD_RESET) begin
          next_st.ccnt = '0;
        end
        // pin still high keeps reset between machine-cycle samples
        if (!rst_pin_s) begin
          next_st.hold_cnt = st.hold_cnt - 2'h1;
          if (st.hold_cnt == 2'h0) begin
            next_st.mode = PMCM_RUN;
          end
        end
      end
      default: next_st.mode = PMCM_RUN;
    endcase
    // any reset ends idle at once and forces divide four
    if (any_rst && st.mode != PMCM_PDOWN && st.mode != PMCM_WARM) begin
      next_st.mode = PMCM_RESET;
      next_st.int_rst = 1'b1;
      next_st.hold_cnt = 2'h1;
      next_st.idle_pend = 1'b0;
      next_st.pd_pend = 1'b0;
      next_st.cd = CD_RESET;
      next_st.cd_pend_v = 1'b0;
      next_st.ccnt = '0;
      next_st.wdt_arm = 1'b0;
    end
    next_st.pins.ale = next_st.mode == PMCM_IDLE;
    next_st.pins.prog_store_strobe = next_st.mode == PMCM_IDLE;
    next_st.pins.rd_n = 1'b1;
    next_st.pins.wr_n = 1'b1;
    next_st.pins.port0_float = ext_code_i && next_st.mode != PMCM_RUN;
    next_st.pins.port_hold = next_st.mode != PMCM_RUN;
    // only the cpu enable drops in idle; power-down stops the oscillator
    next_st.cpu_en = next_st.mode == PMCM_RUN;
    next_st.osc_run = next_st.mode != PMCM_PDOWN;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.mode <= PMCM_RUN;
      st.cd <= CD_RESET;
      st.cd_pend <= CD_RESET;
      st.src <= 1'b1;
      st.xready <= 1'b1;
      st.rx_prev <= 1'b1;
      st.pins.rd_n <= 1'b1;
      st.pins.wr_n <= 1'b1;
      st.cpu_en <= 1'b1;
      st.osc_run <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cpu_clk_en_o = st.cpu_en;
  assign osc_run_o = st.osc_run;
  assign periph_tick_o = st.periph_tick;
  assign core_tick_o = st.core_tick;
  assign int_rst_o = st.int_rst;
  assign int_wake_o = st.wake;
  assign idle_bit_o = st.idle_pend;
  assign pdown_bit_o = st.pd_pend;
  assign clk_div_o = st.cd;
  assign clk_src_select_o = st.src;
  assign rc_active_status_o = st.rc_act;
  assign crystal_amp_off_o = st.xoff;
  assign crystal_ready_o = st.xready;
  assign switchback_enable_o = st.switchback_enable;
  assign rc_wake_select_o = st.rcw;
  assign pins_o = st.pins;

  ////////////////////////////////////////////////////////////////////////////
  a_div_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    st.int_rst |-> st.cd == CD_DIV4)
    else $error("divider not four during reset");
  a_pd_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    st.mode == PMCM_PDOWN |=> !pins_o.ale && !pins_o.prog_store_strobe && pins_o.rd_n)
    else $error("power-down pin levels wrong");
  a_idle_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.mode == PMCM_IDLE && $past(st.mode) == PMCM_IDLE) |-> pins_o.ale && pins_o.wr_n)
    else $error("idle strobes not high");
  a_idle_cpu: assert property (@(posedge clk_i) disable iff (rst_i)
    st.mode == PMCM_IDLE |=> (!cpu_clk_en_o || st.mode != PMCM_IDLE))
    else $error("cpu clock running in idle");
  a_xtal_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_i.src_wr && ctrl_i.src_val && !st.xready && !st.src_pend_v) |=> !st.src_pend_v)
    else $error("crystal select accepted before ready");
  a_swb_div4: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.switchback_enable && ser_tx_wr_i && !ctrl_i.swb_wr) |=> st.cd == CD_DIV4)
    else $error("switchback did not restore divide four");
  a_div_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.switchback_enable && ser_busy_i && ctrl_i.div_wr && !st.cd_pend_v) |=> !st.cd_pend_v)
    else $error("divide write accepted during serial transfer");
  a_pd_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.mode == PMCM_WARM && $past(st.mode) == PMCM_WARM && wu_done && !st.pd_by_rst)
    |=> !pdown_bit_o)
    else $error("power-down bit not cleared on exit");
endmodule : pmcm_top

// ===== tb.sv
// self-checking testbench for the power mode clock manager
`timescale 1ns/100ps
module tb;
  import pmcm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  pmcm_ctrl_s ctrl_i = '0;
  logic instr_done_i = 1'b0;
  logic ext_rst_pin_i = 1'b0;
  logic por_rst_i = 1'b0;
  logic wdt_timeout_i = 1'b0;
  logic wdt_clear_i = 1'b0;
  logic wdt_rst_en_i = 1'b0;
  logic int_pending_i = 1'b0;
  logic ext_int_ack_i = 1'b0;
  logic global_int_enable_i = 1'b0;
  logic lvl_int_wake_en_i = 1'b0;
  logic lvl_int_pin_n_i = 1'b1;
  logic ser_rx_pin_i = 1'b1;
  logic ser_rx_en_i = 1'b0;
  logic ser_tx_wr_i = 1'b0;
  logic ser_busy_i = 1'b0;
  logic ext_code_i = 1'b0;
  logic cpu_clk_en_o, periph_tick_o, core_tick_o, int_rst_o, int_wake_o;
  logic idle_bit_o, pdown_bit_o, clk_src_select_o, rc_active_status_o;
  logic crystal_amp_off_o, crystal_ready_o, switchback_enable_o, rc_wake_select_o, osc_run_o;
  logic [1:0] clk_div_o;
  pmcm_pins_s pins_o;
  int mismatches = 0;
  int num_checks = 0;

  pmcm_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .ctrl_i(ctrl_i), .instr_done_i(instr_done_i),
    .ext_rst_pin_i(ext_rst_pin_i), .por_rst_i(por_rst_i), .wdt_timeout_i(wdt_timeout_i),
    .wdt_clear_i(wdt_clear_i), .wdt_rst_en_i(wdt_rst_en_i), .int_pending_i(int_pending_i),
    .ext_int_ack_i(ext_int_ack_i), .global_int_enable_i(global_int_enable_i),
    .lvl_int_wake_en_i(lvl_int_wake_en_i), .lvl_int_pin_n_i(lvl_int_pin_n_i),
    .ser_rx_pin_i(ser_rx_pin_i), .ser_rx_en_i(ser_rx_en_i), .ser_tx_wr_i(ser_tx_wr_i),
    .ser_busy_i(ser_busy_i), .ext_code_i(ext_code_i), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_tick_o(periph_tick_o), .core_tick_o(core_tick_o), .int_rst_o(int_rst_o),
    .int_wake_o(int_wake_o), .idle_bit_o(idle_bit_o), .pdown_bit_o(pdown_bit_o),
    .clk_div_o(clk_div_o), .clk_src_select_o(clk_src_select_o),
    .rc_active_status_o(rc_active_status_o), .crystal_amp_off_o(crystal_amp_off_o),
    .crystal_ready_o(crystal_ready_o), .switchback_enable_o(switchback_enable_o),
    .rc_wake_select_o(rc_wake_select_o), .osc_run_o(osc_run_o), .pins_o(pins_o)
  );

  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if ((mismatches == 0) && (num_checks > 0)) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic test_end(input string name);
    $display("test %s done at %0t, mismatches so far %0d", name, $time, mismatches);
  endtask : test_end

  task automatic reset_dut();
    rst_i = 1'b1;
    cyc(16);
    rst_i = 1'b0;
    cyc(1);
  endtask : reset_dut

  // one-cycle control strobe: 0 idle, 1 pdown, 2 div, 3 src, 4 xoff, 5 swb, 6 rcw
  task automatic wr(input int f, input logic [1:0] v);
    pmcm_ctrl_s c;
    c = '0;
    case (f)
      0: c.idle_wr = 1'b1;
      1: c.pdown_wr = 1'b1;
      2: begin c.div_wr = 1'b1; c.div_val = v; end
      3: begin c.src_wr = 1'b1; c.src_val = v[0]; end
      4: begin c.xoff_wr = 1'b1; c.xoff_val = v[0]; end
      5: begin c.swb_wr = 1'b1; c.swb_val = v[0]; end
      default: begin c.rcw_wr = 1'b1; c.rcw_val = v[0]; end
    endcase
    ctrl_i = c;
    cyc(1);
    ctrl_i = '0;
    cyc(1);
  endtask : wr

  // instruction boundary, then let the pending value land
  task automatic instr();
    instr_done_i = 1'b1;
    cyc(1);
    instr_done_i = 1'b0;
    cyc(3);
  endtask : instr

  function automatic logic cond(input int sel);
    case (sel)
      0: cond = int_wake_o;
      1: cond = int_rst_o;
      2: cond = (clk_div_o == CD_DIV4);
      3: cond = core_tick_o;
      4: cond = periph_tick_o;
      default: cond = ~int_rst_o;
    endcase
  endfunction : cond

  task automatic wait_for(input int sel, input int lim, output int n);
    n = 0;
    while ((cond(sel) !== 1'b1) && (n < lim)) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_for

  // cycles between two successive tick pulses
  task automatic tick_gap(input int sel, output int gap);
    int n;
    wait_for(sel, 2100, n);
    @(negedge clk_i);
    gap = 1;
    while ((cond(sel) !== 1'b1) && (gap < 2100)) begin
      @(negedge clk_i);
      gap++;
    end
  endtask : tick_gap

  task automatic set_div(input logic [1:0] v);
    wr(2, v);
    instr();
  endtask : set_div

  ////////////////////////////////////////////////////////////////////////////
  // whole run is about 71k cycles; the power-down warm-up dominates
  initial begin
    #(100000 * CLK_PERIOD_NS);
    mismatches++;
    summarize();
  end

  initial begin
    int n;
    int m;
    int g;
    reset_dut();
    chk(clk_div_o, CD_RESET);
    chk({clk_src_select_o, crystal_ready_o, cpu_clk_en_o, osc_run_o}, 4'hf);
    chk({idle_bit_o, pdown_bit_o, pins_o.rd_n, pins_o.wr_n}, 4'h3);
    tick_gap(3, g);
    chk(g, 4);
    test_end("reset_state");

    wr(2, CD_DIV64);
    cyc(4);
    chk(clk_div_o, CD_DIV4);
    instr();
    chk(clk_div_o, CD_DIV64);
    tick_gap(3, g);
    tick_gap(3, g);
    chk(g, 64);
    tick_gap(4, g);
    chk(g, 64);
    set_div(CD_DIV4);
    chk(clk_div_o, CD_DIV4);
    set_div(CD_DIV1024);
    chk(clk_div_o, CD_DIV1024);
    tick_gap(3, g);
    tick_gap(3, g);
    chk(g, 1024);
    set_div(CD_RSVD);
    chk(clk_div_o, CD_DIV1024);
    test_end("divide");

    reset_dut();
    ser_rx_en_i = 1'b1;
    global_int_enable_i = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(5, (k != 3));
      set_div(CD_DIV64);
      case (k)
        1: ser_rx_pin_i = 1'b0;
        2: ext_int_ack_i = 1'b1;
        default: ser_tx_wr_i = 1'b1;
      endcase
      cyc(1);
      ser_tx_wr_i = 1'b0;
      ext_int_ack_i = 1'b0;
      wait_for(2, 8, n);
      chk(clk_div_o, (k == 3) ? CD_DIV64 : CD_DIV4);
      ser_rx_pin_i = 1'b1;
      set_div(CD_DIV4);
    end
    wr(5, 2'h1);
    chk(switchback_enable_o, 1'b1);
    ser_busy_i = 1'b1;
    set_div(CD_DIV64);
    chk(clk_div_o, CD_DIV4);
    ser_busy_i = 1'b0;
    ser_rx_en_i = 1'b0;
    test_end("switchback");

    reset_dut();
    ext_code_i = 1'b1;
    wr(0, 2'h1);
    chk(cpu_clk_en_o, 1'b1);
    instr();
    chk({idle_bit_o, cpu_clk_en_o}, 2'h2);
    tick_gap(4, g);
    chk(g, 4);
    chk({pins_o.ale, pins_o.prog_store_strobe, pins_o.rd_n, pins_o.wr_n}, 4'hf);
    chk({pins_o.port0_float, pins_o.port_hold}, 2'h3);
    int_pending_i = 1'b1;
    wait_for(0, 8, n);
    chk(int_wake_o, 1'b1);
    cyc(2);
    int_pending_i = 1'b0;
    chk({idle_bit_o, cpu_clk_en_o}, 2'h1);
    test_end("idle_interrupt");

    wr(0, 2'h1);
    instr();
    ext_rst_pin_i = 1'b1;
    cyc(2);
    ext_rst_pin_i = 1'b0;
    cyc(12);
    chk({int_rst_o, idle_bit_o}, 2'h1);
    ext_rst_pin_i = 1'b1;
    wait_for(1, 16, n);
    chk(int_rst_o, 1'b1);
    ext_rst_pin_i = 1'b0;
    wait_for(5, 16, n);
    chk({int_rst_o, idle_bit_o, cpu_clk_en_o}, 3'h1);
    test_end("idle_ext_reset");

    reset_dut();
    wdt_rst_en_i = 1'b1;
    set_div(CD_DIV64);
    wr(0, 2'h1);
    instr();
    wdt_timeout_i = 1'b1;
    cyc(1);
    wdt_timeout_i = 1'b0;
    wait_for(0, 8, n);
    chk(int_wake_o, 1'b1);
    wait_for(1, 600, m);
    chk(n + m, WDT_RESET_CLKS);
    chk(clk_div_o, CD_DIV4);
    wait_for(5, 40, n);
    wdt_timeout_i = 1'b1;
    cyc(1);
    wdt_timeout_i = 1'b0;
    cyc(100);
    wdt_clear_i = 1'b1;
    cyc(1);
    wdt_clear_i = 1'b0;
    cyc(600);
    chk(int_rst_o, 1'b0);
    wdt_rst_en_i = 1'b0;
    set_div(CD_DIV64);
    por_rst_i = 1'b1;
    cyc(4);
    por_rst_i = 1'b0;
    cyc(2);
    chk(clk_div_o, CD_DIV4);
    wait_for(5, 40, n);
    test_end("watchdog");

    reset_dut();
    wr(3, 2'h0);
    chk(rc_active_status_o, 1'b0);
    instr();
    chk({clk_src_select_o, rc_active_status_o}, 2'h1);
    wr(4, 2'h1);
    chk({crystal_amp_off_o, crystal_ready_o}, 2'h2);
    wr(3, 2'h1);
    instr();
    chk({clk_src_select_o, rc_active_status_o}, 2'h1);
    // amplifier back on after the refused crystal select
    wr(4, 2'h0);
    chk(crystal_amp_off_o, 1'b0);
    wr(6, 2'h1);
    chk(rc_wake_select_o, 1'b1);
    wr(6, 2'h0);
    test_end("clock_source");

    reset_dut();
    global_int_enable_i = 1'b1;
    lvl_int_wake_en_i = 1'b1;
    wr(1, 2'h1);
    chk(pdown_bit_o, 1'b1);
    instr();
    cyc(1);
    chk(osc_run_o, 1'b0);
    chk({pins_o.ale, pins_o.prog_store_strobe, pins_o.rd_n, pins_o.wr_n}, 4'h3);
    wdt_timeout_i = 1'b1;
    cyc(1);
    wdt_timeout_i = 1'b0;
    cyc(20);
    chk({pdown_bit_o, osc_run_o}, 2'h2);
    lvl_int_pin_n_i = 1'b0;
    wait_for(0, 66000, n);
    chk(int_wake_o, 1'b1);
    chk((n >= WARMUP_CLKS) && (n <= WARMUP_CLKS + 24), 1'b1);
    lvl_int_pin_n_i = 1'b1;
    cyc(2);
    chk({pdown_bit_o, osc_run_o, cpu_clk_en_o, crystal_ready_o}, 4'h7);
    test_end("power_down");

    reset_dut();
    wr(6, 2'h1);
    wr(1, 2'h1);
    instr();
    ext_rst_pin_i = 1'b1;
    wait_for(1, 16, n);
    chk(int_rst_o, 1'b1);
    chk({clk_src_select_o, rc_active_status_o, pdown_bit_o}, 3'h2);
    ext_rst_pin_i = 1'b0;
    wait_for(5, 16, n);
    chk({int_rst_o, rc_active_status_o, crystal_ready_o}, 3'h2);
    test_end("rc_wake");
    summarize();
  end
endmodule : tb
